// ---- include/exec_regs.svh ----
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH

// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define FLAG_POS_C 3'h0
`define FLAG_POS_Z 3'h1
`define FLAG_POS_N 3'h2
`define FLAG_POS_V 3'h3
`define FLAG_POS_S 3'h4
`define FLAG_POS_H 3'h5
`define FLAG_POS_T 3'h6
`define FLAG_POS_I 3'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FLAG_RESET 8'h00
`define GPR_RESET 8'h00
`define MEM_ADDR_RESET 16'h0000

// ----------------------------------------
// Pointer pair base registers (low byte)
// ----------------------------------------
`define PTR_X_BASE 5'h1a
`define PTR_Y_BASE 5'h1c
`define PTR_Z_BASE 5'h1e

// ----------------------------------------
// Timing counts in clock cycles
// ----------------------------------------
`define ALU_OP_CYCLES 1
`define MEM_OP_CYCLES 2

`endif

// ---- include/exec_pkg.sv ----
// ----------------------------------------
// Shared types of the execution core
// ----------------------------------------
package exec_pkg;

    // Operation selector
    typedef enum logic [3:0] {
        OP_ROTATE_RIGHT_VIA_CARRY,
        OP_ARITH_SHIFT_RIGHT,
        OP_NIBBLE_SWAP,
        OP_FLAG_SET_BY_INDEX,
        OP_FLAG_CLEAR_BY_INDEX,
        OP_COPY_BIT_TO_TRANSFER_FLAG,
        OP_COPY_TRANSFER_FLAG_TO_BIT,
        OP_COPY_REGISTER,
        OP_COPY_REGISTER_PAIR,
        OP_LOAD_IMMEDIATE,
        OP_LOAD,
        OP_WRITE
    } op_type;

    // Addressing mode of a load or write
    typedef enum logic [2:0] {
        AM_PLAIN,
        AM_POST_INC,
        AM_PRE_DEC,
        AM_DISPLACED,
        AM_DIRECT
    } amode_type;

    // Pointer pair selector
    typedef enum logic [1:0] {
        PTR_X,
        PTR_Y,
        PTR_Z
    } ptr_type;

    // One command to the core
    typedef struct packed {
        op_type op;
        amode_type mode;
        ptr_type ptr;
        logic [4:0] dst;
        logic [4:0] src;
        logic [2:0] bit_sel;
        logic [7:0] imm;
        logic [15:0] addr;
    } cmd_type;

    // Data memory request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic re;
        logic we;
    } mem_req_type;

endpackage : exec_pkg

// ---- logic/gp_register_file.sv ----
`timescale 1ns/1ps
`include "exec_regs.svh"

// ----------------------------------------
// 32 x 8 general register file
// ----------------------------------------
module gp_register_file (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [4:0] a_addr_in,
    output logic [7:0] a_data_out,
    input wire logic [4:0] b_addr_in,
    output logic [7:0] b_data_out,
    input wire logic [4:0] p_addr_in,
    output logic [15:0] p_data_out,
    input wire logic w_en_in,
    input wire logic w_pair_in,
    input wire logic [4:0] w_addr_in,
    input wire logic [15:0] w_data_in,
    input wire logic [4:0] peek_addr_in,
    output logic [7:0] peek_data_out
);

    logic [7:0] regs_r [32]; // Register storage

    // ----------------------------------------
    // Per-register write, pair writes land on both halves
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : gen_reg
            logic hit; // This register is written
            assign hit = w_en_in && (w_pair_in ? (w_addr_in[4:1] == 4'(g / 2)) : (w_addr_in == 5'(g)));
            // Odd half of a pair takes the upper byte
            always_ff @(posedge sys_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    regs_r[g] <= `GPR_RESET;
                end else if (hit) begin
                    regs_r[g] <= (w_pair_in && (g % 2 == 1)) ? w_data_in[15:8] : w_data_in[7:0];
                end
            end
        end
    endgenerate

    // Core read ports, flop outputs read directly for single-cycle ops
    assign a_data_out = regs_r[a_addr_in];
    assign b_data_out = regs_r[b_addr_in];
    assign p_data_out = {regs_r[{p_addr_in[4:1], 1'b1}], regs_r[{p_addr_in[4:1], 1'b0}]};

    // Observation port, registered
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            peek_data_out <= `GPR_RESET;
        end else begin
            peek_data_out <= regs_r[peek_addr_in];
        end
    end

endmodule : gp_register_file

// ---- logic/bitops_load_store_exec.sv ----
`timescale 1ns/1ps
`include "exec_regs.svh"

// Operation
// - Rotate right through carry, one cycle
// - Arithmetic shift right keeps sign, one cycle
// - Set or clear any flag by index
// - Copy register bit into transfer flag
// - Copy transfer flag into register bit
// - Load then increment pointer, two cycles
// - Decrement pointer then load, two cycles
// - Load from pointer plus displacement, two cycles
// - Load from direct address, two cycles
// - Write then increment pointer, two cycles
// - Decrement pointer then write, two cycles
// - Write to pointer plus displacement, two cycles
module bitops_load_store_exec (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic cmd_valid_in,
    input wire exec_pkg::cmd_type cmd_in,
    output logic cmd_ready_out,
    output logic done_out,
    output exec_pkg::mem_req_type mem_req_out,
    input wire logic [7:0] mem_rdata_in,
    output logic [7:0] flag_register_out,
    input wire logic [4:0] peek_addr_in,
    output logic [7:0] peek_data_out
);

    // ----------------------------------------
    // Local state and helpers
    // ----------------------------------------
    typedef enum logic {PH_IDLE, PH_MEM} state_type;

    state_type state_r; // Idle or memory phase
    logic [7:0] flag_r; // Status flags
    logic [4:0] dst_r; // Load destination held over the memory phase
    logic load_r; // Memory phase is a load
    logic done_r; // Completion pulse
    logic [15:0] maddr_r; // Memory address
    logic [7:0] mwdata_r; // Memory write data
    logic [7:0] a_data; // Destination register value
    logic [7:0] b_data; // Source register value
    logic [15:0] p_data; // Pointer or source pair value
    logic [4:0] p_addr; // Pair read select
    logic accept; // Command taken this edge
    logic is_mem; // Command uses data memory
    logic ptr_update; // Command moves its pointer
    logic [15:0] eff_addr; // Effective memory address
    logic [15:0] ptr_next; // Updated pointer value
    logic [7:0] shift_res; // Rotate or shift result
    logic w_en; // Register write enable
    logic w_pair; // Register write is a pair
    logic [4:0] w_addr; // Register write address
    logic [15:0] w_data; // Register write data

    // Pointer pair base register
    function automatic logic [4:0] ptr_base(input exec_pkg::ptr_type p);
        unique case (p)
            exec_pkg::PTR_X: ptr_base = `PTR_X_BASE;
            exec_pkg::PTR_Y: ptr_base = `PTR_Y_BASE;
            exec_pkg::PTR_Z: ptr_base = `PTR_Z_BASE;
            default: ptr_base = `PTR_Z_BASE;
        endcase
    endfunction : ptr_base

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Memory ops hold off the next command for one cycle
    assign cmd_ready_out = (state_r == PH_IDLE);
    assign accept = cmd_valid_in && cmd_ready_out;
    assign is_mem = (cmd_in.op == exec_pkg::OP_LOAD) || (cmd_in.op == exec_pkg::OP_WRITE);
    assign ptr_update = is_mem && ((cmd_in.mode == exec_pkg::AM_POST_INC) || (cmd_in.mode == exec_pkg::AM_PRE_DEC));
    // Pair copy reads the even-aligned source pair through the pointer port
    assign p_addr = (cmd_in.op == exec_pkg::OP_COPY_REGISTER_PAIR) ? {cmd_in.src[4:1], 1'b0} : ptr_base(cmd_in.ptr);

    // Rotate pulls old carry in, shift replicates the sign
    assign shift_res = (cmd_in.op == exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY) ?
        {flag_r[`FLAG_POS_C], a_data[7:1]} : {a_data[7], a_data[7:1]};

    // ----------------------------------------
    // Address generation
    // ----------------------------------------
    always_comb begin
        eff_addr = p_data;
        ptr_next = p_data;
        unique case (cmd_in.mode)
            exec_pkg::AM_PLAIN: begin
                eff_addr = p_data;
            end
            exec_pkg::AM_POST_INC: begin
                eff_addr = p_data;
                ptr_next = p_data + 16'h0001;
            end
            exec_pkg::AM_PRE_DEC: begin
                eff_addr = p_data - 16'h0001;
                ptr_next = p_data - 16'h0001;
            end
            exec_pkg::AM_DISPLACED: begin
                // Displacement is six bits, pointer untouched
                eff_addr = p_data + {10'h000, cmd_in.imm[5:0]};
            end
            exec_pkg::AM_DIRECT: begin
                eff_addr = cmd_in.addr;
            end
            default: begin
                eff_addr = p_data;
            end
        endcase
    end

    // ----------------------------------------
    // Register write port
    // ----------------------------------------
    // One write per cycle; post-increment and pre-decrement loads write the pointer first and data next cycle
    always_comb begin
        w_en = 1'b0;
        w_pair = 1'b0;
        w_addr = cmd_in.dst;
        w_data = {8'h00, a_data};
        if (state_r == PH_MEM) begin
            // Memory phase: only a load writes its destination
            w_en = load_r;
            w_addr = dst_r;
            w_data = {8'h00, mem_rdata_in};
        end else if (accept) begin
            unique case (cmd_in.op)
                exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY, exec_pkg::OP_ARITH_SHIFT_RIGHT: begin
                    w_en = 1'b1;
                    w_data = {8'h00, shift_res};
                end
                exec_pkg::OP_NIBBLE_SWAP: begin
                    w_en = 1'b1;
                    w_data = {8'h00, a_data[3:0], a_data[7:4]};
                end
                exec_pkg::OP_COPY_TRANSFER_FLAG_TO_BIT: begin
                    w_en = 1'b1;
                    w_data = {8'h00, (a_data & ~(8'h01 << cmd_in.bit_sel)) |
                        ({7'h00, flag_r[`FLAG_POS_T]} << cmd_in.bit_sel)};
                end
                exec_pkg::OP_COPY_REGISTER: begin
                    w_en = 1'b1;
                    w_data = {8'h00, b_data};
                end
                exec_pkg::OP_COPY_REGISTER_PAIR: begin
                    w_en = 1'b1;
                    w_pair = 1'b1;
                    w_addr = {cmd_in.dst[4:1], 1'b0};
                    w_data = p_data;
                end
                exec_pkg::OP_LOAD_IMMEDIATE: begin
                    w_en = 1'b1;
                    w_data = {8'h00, cmd_in.imm};
                end
                exec_pkg::OP_LOAD, exec_pkg::OP_WRITE: begin
                    // Pointer moves at the first edge
                    w_en = ptr_update;
                    w_pair = 1'b1;
                    w_addr = ptr_base(cmd_in.ptr);
                    w_data = ptr_next;
                end
                default: begin
                    w_en = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Loads, writes, copies, swap and bit load leave flags alone
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            flag_r <= `FLAG_RESET;
        end else if (accept) begin
            unique case (cmd_in.op)
                exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY, exec_pkg::OP_ARITH_SHIFT_RIGHT: begin
                    flag_r[`FLAG_POS_C] <= a_data[0];
                    flag_r[`FLAG_POS_Z] <= (shift_res == 8'h00);
                    flag_r[`FLAG_POS_N] <= shift_res[7];
                    flag_r[`FLAG_POS_V] <= shift_res[7] ^ a_data[0];
                end
                exec_pkg::OP_FLAG_SET_BY_INDEX: begin
                    flag_r[cmd_in.bit_sel] <= 1'b1;
                end
                exec_pkg::OP_FLAG_CLEAR_BY_INDEX: begin
                    flag_r[cmd_in.bit_sel] <= 1'b0;
                end
                exec_pkg::OP_COPY_BIT_TO_TRANSFER_FLAG: begin
                    flag_r[`FLAG_POS_T] <= b_data[cmd_in.bit_sel];
                end
                default: begin
                    flag_r <= flag_r;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= PH_IDLE;
        end else begin
            unique case (state_r)
                PH_IDLE: begin
                    if (accept && is_mem) begin
                        state_r <= PH_MEM;
                    end
                end
                PH_MEM: begin
                    state_r <= PH_IDLE;
                end
            endcase
        end
    end

    // Completion pulse after the last edge of each command
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            done_r <= 1'b0;
        end else begin
            done_r <= (accept && !is_mem) || (state_r == PH_MEM);
        end
    end

    // ----------------------------------------
    // Memory request registers
    // ----------------------------------------
    // Address and data are captured at accept so outputs come from flops
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            maddr_r <= `MEM_ADDR_RESET;
            mwdata_r <= 8'h00;
            dst_r <= 5'h00;
            load_r <= 1'b0;
        end else if (accept && is_mem) begin
            maddr_r <= eff_addr;
            mwdata_r <= b_data;
            dst_r <= cmd_in.dst;
            load_r <= (cmd_in.op == exec_pkg::OP_LOAD);
        end
    end

    // Strobes stand only in the memory phase
    assign mem_req_out.addr = maddr_r;
    assign mem_req_out.wdata = mwdata_r;
    assign mem_req_out.re = (state_r == PH_MEM) && load_r;
    assign mem_req_out.we = (state_r == PH_MEM) && !load_r;
    assign done_out = done_r;
    assign flag_register_out = flag_r;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    gp_register_file u_regs (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .a_addr_in(cmd_in.dst),
        .a_data_out(a_data),
        .b_addr_in(cmd_in.src),
        .b_data_out(b_data),
        .p_addr_in(p_addr),
        .p_data_out(p_data),
        .w_en_in(w_en),
        .w_pair_in(w_pair),
        .w_addr_in(w_addr),
        .w_data_in(w_data),
        .peek_addr_in(peek_addr_in),
        .peek_data_out(peek_data_out)
    );

endmodule : bitops_load_store_exec

// ---- dv/data_mem_model.sv ----
`timescale 1ns/1ps
// ------------------------------
// Async-read data memory
// ------------------------------
module data_mem_model (
    input wire logic sys_clk_in,
    input wire exec_pkg::mem_req_type req_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem_r [0:65535]; // Whole 64K byte space
    logic [7:0] last_r; // Last byte handed out
    // Seed pattern, so every load has a known answer
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem_r[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5c;
        end
        last_r = 8'h00;
    end
    // Read only while strobed; junk otherwise so a late sample shows
    assign rdata_out = req_in.re ? mem_r[req_in.addr] : ~last_r;
    // Byte write on the strobe edge
    always @(posedge sys_clk_in) begin
        if (req_in.we) begin
            mem_r[req_in.addr] <= req_in.wdata;
        end
        last_r <= req_in.re ? mem_r[req_in.addr] : ~last_r;
    end
endmodule : data_mem_model

// ---- dv/exec_chk.sv ----
`timescale 1ns/1ps
// ------------------------------
// Port checker
// ------------------------------
module exec_chk (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic cmd_valid_in,
    input wire exec_pkg::cmd_type cmd_in,
    input wire logic cmd_ready_out,
    input wire logic done_out,
    input wire exec_pkg::mem_req_type mem_req_out,
    input wire logic [7:0] flag_register_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);
    logic take; // Command taken at this edge
    logic mem_op; // Taken command reaches memory
    logic quiet; // Command that must leave flags alone
    logic strobe; // Memory cycle in progress
    assign take = cmd_valid_in && cmd_ready_out;
    assign mem_op = cmd_in.op inside {exec_pkg::OP_LOAD, exec_pkg::OP_WRITE};
    assign quiet = mem_op || cmd_in.op inside {exec_pkg::OP_NIBBLE_SWAP, exec_pkg::OP_COPY_TRANSFER_FLAG_TO_BIT,
        exec_pkg::OP_COPY_REGISTER, exec_pkg::OP_COPY_REGISTER_PAIR, exec_pkg::OP_LOAD_IMMEDIATE};
    assign strobe = mem_req_out.re || mem_req_out.we;
    a_single_done: assert property (take && !mem_op |=> done_out)
        else $error("single op not done next cycle");
    a_mem_two_cycles: assert property (take && mem_op |=> !cmd_ready_out && !done_out ##1 cmd_ready_out && done_out)
        else $error("memory op not two cycles");
    a_load_strobe: assert property (take && cmd_in.op == exec_pkg::OP_LOAD |=> mem_req_out.re && !mem_req_out.we)
        else $error("load without read strobe");
    a_write_strobe: assert property (take && cmd_in.op == exec_pkg::OP_WRITE |=> mem_req_out.we && !mem_req_out.re)
        else $error("write without write strobe");
    a_strobe_once: assert property (strobe |=> !strobe)
        else $error("memory strobe held two cycles");
    a_flags_kept: assert property (take && quiet |=> $stable(flag_register_out))
        else $error("flags changed by flag-neutral op");
    a_flag_set: assert property (take && cmd_in.op == exec_pkg::OP_FLAG_SET_BY_INDEX |=>
        flag_register_out == ($past(flag_register_out) | (8'h01 << $past(cmd_in.bit_sel))))
        else $error("flag set wrong");
    a_flag_clear: assert property (take && cmd_in.op == exec_pkg::OP_FLAG_CLEAR_BY_INDEX |=>
        flag_register_out == ($past(flag_register_out) & ~(8'h01 << $past(cmd_in.bit_sel))))
        else $error("flag clear wrong");
    a_shift_flags: assert property (take && cmd_in.op inside {exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
        exec_pkg::OP_ARITH_SHIFT_RIGHT} |=> flag_register_out[3] == (flag_register_out[2] ^ flag_register_out[0])
        && flag_register_out[7:4] == $past(flag_register_out[7:4]))
        else $error("shift flags wrong");
    a_transfer_only: assert property (take && cmd_in.op == exec_pkg::OP_COPY_BIT_TO_TRANSFER_FLAG |=>
        (flag_register_out & 8'hbf) == ($past(flag_register_out) & 8'hbf))
        else $error("bit store touched other flags");
endmodule : exec_chk

bind bitops_load_store_exec exec_chk u_chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
    .mem_req_out(mem_req_out), .flag_register_out(flag_register_out));

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
// ------------------------------
// Bench for the bit and load/write core
// ------------------------------
module tb_top;
    logic sys_clk_in;
    logic reset_in;
    logic cmd_valid_in;
    exec_pkg::cmd_type cmd_in;
    logic cmd_ready_out;
    logic done_out;
    exec_pkg::mem_req_type mem_req_out;
    logic [7:0] mem_rdata_in;
    logic [7:0] flag_register_out;
    logic [4:0] peek_addr_in;
    logic [7:0] peek_data_out;
    logic [7:0] rv; // Last register peeked
    logic [7:0] ef; // Flags we expect
    int miscompares;
    int checks;

    bitops_load_store_exec u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
        .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out), .mem_req_out(mem_req_out),
        .mem_rdata_in(mem_rdata_in), .flag_register_out(flag_register_out), .peek_addr_in(peek_addr_in),
        .peek_data_out(peek_data_out));
    data_mem_model u_mem (.sys_clk_in(sys_clk_in), .req_in(mem_req_out), .rdata_out(mem_rdata_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Same seed pattern the memory model starts with
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5c;
    endfunction : pat

    // One command held a single cycle, then timed until done
    task automatic run(input exec_pkg::op_type op, input exec_pkg::amode_type md, input int p,
        input logic [4:0] d, input logic [4:0] s, input logic [2:0] b, input logic [7:0] k, input logic [15:0] a);
        int n;
        @(negedge sys_clk_in);
        cmd_in = '{op, md, exec_pkg::ptr_type'(p), d, s, b, k, a};
        cmd_valid_in = 1'b1;
        @(negedge sys_clk_in);
        cmd_valid_in = 1'b0;
        n = 1;
        while (done_out !== 1'b1 && n < 8) begin
            @(negedge sys_clk_in);
            n++;
        end
        check("latency", 16'(n), op inside {exec_pkg::OP_LOAD, exec_pkg::OP_WRITE} ? 16'h0002 : 16'h0001);
    endtask : run

    task automatic op1(input exec_pkg::op_type op, input logic [4:0] d, input logic [4:0] s, input logic [2:0] b);
        run(op, exec_pkg::AM_PLAIN, 0, d, s, b, '0, '0);
    endtask : op1

    task automatic li(input logic [4:0] d, input logic [7:0] k);
        run(exec_pkg::OP_LOAD_IMMEDIATE, exec_pkg::AM_PLAIN, 0, d, d, '0, k, '0);
    endtask : li

    // Peek output lags its address by one edge
    task automatic peek(input logic [4:0] r);
        @(negedge sys_clk_in);
        peek_addr_in = r;
        @(negedge sys_clk_in);
        rv = peek_data_out;
    endtask : peek

    task automatic setp(input int p, input logic [15:0] v);
        li(5'(26 + 2 * p), v[7:0]);
        li(5'(27 + 2 * p), v[15:8]);
    endtask : setp

    task automatic pchk(input int p, input logic [15:0] e);
        logic [7:0] lo;
        peek(5'(26 + 2 * p));
        lo = rv;
        peek(5'(27 + 2 * p));
        check("pointer", {rv, lo}, e);
    endtask : pchk

    task automatic t_shift();
        logic [15:0] e [4] = '{16'h4029, 16'ha02c, 16'hd02c, 16'h002b};
        op1(exec_pkg::OP_FLAG_SET_BY_INDEX, '0, '0, 3'h5);
        li(5'h10, 8'h81);
        li(5'h11, 8'h01);
        for (int i = 0; i < 4; i++) begin
            op1(i < 2 ? exec_pkg::OP_ROTATE_RIGHT_VIA_CARRY : exec_pkg::OP_ARITH_SHIFT_RIGHT,
                5'(i == 3 ? 17 : 16), 5'(i == 3 ? 17 : 16), '0);
            peek(5'(i == 3 ? 17 : 16));
            check("shift data", rv, e[i][15:8]);
            check("shift flags", flag_register_out, e[i][7:0]);
        end
        ef = 8'h2b;
        $display("shift test finished");
    endtask : t_shift

    task automatic t_flags();
        for (int i = 0; i < 16; i++) begin
            op1(i < 8 ? exec_pkg::OP_FLAG_SET_BY_INDEX : exec_pkg::OP_FLAG_CLEAR_BY_INDEX, '0, '0, i[2:0]);
            ef = i < 8 ? ef | (8'h01 << i[2:0]) : ef & ~(8'h01 << i[2:0]);
            check("flags", flag_register_out, ef);
        end
        $display("flag test finished");
    endtask : t_flags

    task automatic t_xfer();
        li(5'h12, 8'h5a);
        op1(exec_pkg::OP_COPY_BIT_TO_TRANSFER_FLAG, '0, 5'h12, 3'h3);
        check("transfer set", flag_register_out, 8'h40);
        op1(exec_pkg::OP_COPY_BIT_TO_TRANSFER_FLAG, '0, 5'h12, 3'h0);
        check("transfer clear", flag_register_out, 8'h00);
        peek(5'h12);
        check("source kept", rv, 8'h5a);
        op1(exec_pkg::OP_COPY_BIT_TO_TRANSFER_FLAG, '0, 5'h12, 3'h1);
        op1(exec_pkg::OP_COPY_TRANSFER_FLAG_TO_BIT, 5'h13, '0, 3'h7);
        peek(5'h13);
        check("bit loaded", rv, 8'h80);
        ef = 8'h40;
        check("flags kept", flag_register_out, ef);
        $display("transfer test finished");
    endtask : t_xfer

    task automatic t_move();
        logic [7:0] e [4] = '{8'hc3, 8'h7e, 8'hc3, 8'h7e};
        logic [4:0] g [4] = '{5'h14, 5'h18, 5'h16, 5'h17};
        li(5'h14, 8'h3c);
        li(5'h15, 8'h7e);
        op1(exec_pkg::OP_NIBBLE_SWAP, 5'h14, 5'h14, '0);
        op1(exec_pkg::OP_COPY_REGISTER, 5'h18, 5'h15, '0);
        op1(exec_pkg::OP_COPY_REGISTER_PAIR, 5'h16, 5'h14, '0);
        for (int i = 0; i < 4; i++) begin
            peek(g[i]);
            check("moved", rv, e[i]);
        end
        check("flags kept", flag_register_out, ef);
        $display("move test finished");
    endtask : t_move

    // Z starts at zero so pre-decrement wraps to the top of memory
    task automatic t_load();
        logic [15:0] b [3] = '{16'h0100, 16'h01ff, 16'h0000};
        logic [15:0] pv;
        for (int p = 0; p < 3; p++) begin
            setp(p, b[p]);
            for (int s = 0; s < 3; s++) begin
                run(exec_pkg::OP_LOAD, s == 0 ? exec_pkg::AM_POST_INC : exec_pkg::AM_PRE_DEC, p, 5'h10, '0, '0, '0, '0);
                pv = b[p] + 16'h0001 - 16'(s);
                peek(5'h10);
                check("load data", rv, pat(s == 0 ? b[p] : pv));
                pchk(p, pv);
            end
            if (p > 0) begin
                run(exec_pkg::OP_LOAD, exec_pkg::AM_DISPLACED, p, 5'h10, '0, '0, 8'h2a, '0);
                peek(5'h10);
                check("displaced data", rv, pat(pv + 16'h002a));
                pchk(p, pv);
            end
        end
        // Plain mode through X, which the loop above left at 00ff
        run(exec_pkg::OP_LOAD, exec_pkg::AM_PLAIN, 0, 5'h12, '0, '0, '0, '0);
        peek(5'h12);
        check("plain data", rv, pat(16'h00ff));
        pchk(0, 16'h00ff);
        run(exec_pkg::OP_LOAD, exec_pkg::AM_DIRECT, 0, 5'h11, '0, '0, '0, 16'h0777);
        peek(5'h11);
        check("direct data", rv, pat(16'h0777));
        check("flags kept", flag_register_out, ef);
        $display("load test finished");
    endtask : t_load

    task automatic t_store();
        li(5'h10, 8'h96);
        setp(0, 16'h0400);
        run(exec_pkg::OP_WRITE, exec_pkg::AM_POST_INC, 0, 5'h10, 5'h10, '0, '0, '0);
        check("post-inc write", u_mem.mem_r[16'h0400], 8'h96);
        pchk(0, 16'h0401);
        li(5'h10, 8'h69);
        run(exec_pkg::OP_WRITE, exec_pkg::AM_PRE_DEC, 0, 5'h10, 5'h10, '0, '0, '0);
        check("pre-dec write", u_mem.mem_r[16'h0400], 8'h69);
        pchk(0, 16'h0400);
        setp(1, 16'h0500);
        run(exec_pkg::OP_WRITE, exec_pkg::AM_DISPLACED, 1, 5'h10, 5'h10, '0, 8'h3f, '0);
        check("displaced write", u_mem.mem_r[16'h053f], 8'h69);
        pchk(1, 16'h0500);
        $display("write test finished");
    endtask : t_store

    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // Main sequence; inputs move on the falling edge only
    initial begin
        reset_in = 1'b1;
        cmd_valid_in = 1'b0;
        cmd_in = '0;
        peek_addr_in = '0;
        miscompares = 0;
        checks = 0;
        ef = '0;
        repeat (5) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        reset_in = 1'b0;
        t_shift();
        t_flags();
        t_xfer();
        t_move();
        t_load();
        t_store();
        give_verdict();
    end

    // Watchdog: run needs a few hundred cycles, allow 20000
    initial begin
        #(20000 * 5);
        miscompares++;
        give_verdict();
    end
endmodule : tb_top
